//--- fw_apb_master.sv
`include "watchdog_map.vh"
`default_nettype none

module fw_apb_master (
    input  wire logic        i_clk_sys,
    input  wire logic        i_pready,
    input  wire logic        i_pslverr,
    input  wire logic [31:0] i_prdata,
    output var  logic        o_psel,
    output var  logic        o_penable,
    output var  logic        o_pwrite,
    output var  logic [23:0] o_paddr,
    output var  logic [31:0] o_pwdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 24'h000000;
        o_pwdata = 32'h00000000;
    end

    task automatic xfer(input logic wr, input logic [23:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err, output logic ok);
        int n;
        ok = 1'b0;
        rdata = 32'h00000000;
        err = 1'b0;
        @(posedge i_clk_sys);
        o_psel <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite <= wr;
        o_paddr <= addr;
        // hold enables of the week and hibernation stalls always zero
        o_pwdata <= (wr && addr == `ADDR_CONTROL) ? (wdata & 32'hFFFFFFF3) : wdata;
        @(posedge i_clk_sys);
        o_penable <= 1'b1;
        for (n = 0; n < 50 && !ok; n++) begin
            @(posedge i_clk_sys);
            if (i_pready === 1'b1) begin
                ok = 1'b1;
                rdata = i_prdata;
                err = i_pslverr;
            end
        end
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        o_pwdata <= ~o_pwdata;
    endtask
endmodule

`default_nettype wire

//--- input_sync2.v
`default_nettype none

module input_sync2 #(
    parameter W = 3
) (
    input  wire         i_clk_sys,
    input  wire         i_rst_n,
    input  wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule

`default_nettype wire

//--- test_watchdog_timer_registers.sv
`include "watchdog_map.vh"
`default_nettype none

module test_watchdog_timer_registers;
    timeunit 1ns;
    timeprecision 1ps;

    logic        i_clk_sys, i_rst_n, i_soft_rst, i_debug_active;
    logic        i_hibernation_active, i_week_timer_active;
    logic        i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_expiry_pulse, o_irq;
    logic [23:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata;
    int          error_cnt, total_checks;

    watchdog_timer_registers #(.TICK_CYC(16'h0008)) watchdog_timer_registers_i (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_soft_rst(i_soft_rst),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata),
        .i_debug_active(i_debug_active), .i_hibernation_active(i_hibernation_active),
        .i_week_timer_active(i_week_timer_active), .o_expiry_pulse(o_expiry_pulse),
        .o_irq(o_irq));

    fw_apb_master fw_apb_master_i (
        .i_clk_sys(i_clk_sys), .i_pready(o_pready), .i_pslverr(o_pslverr),
        .i_prdata(o_prdata), .o_psel(i_psel), .o_penable(i_penable), .o_pwrite(i_pwrite),
        .o_paddr(i_paddr), .o_pwdata(i_pwdata));

    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic wr, input logic [23:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        logic ok;
        fw_apb_master_i.xfer(wr, a, d, q, e, ok);
        if (ok !== 1'b1) begin
            error_cnt++;
            summarize();
        end
    endtask

    task automatic wr(input logic [23:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        bus(1'b1, a, d, q, e);
        chk("pslverr", {31'h0, e}, 32'h0);
    endtask

    task automatic rd_chk(input string what, input logic [23:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        bus(1'b0, a, 32'h0, q, e);
        chk(what, q, exp);
    endtask

    task automatic late_chk(input string what, ref logic v, input logic exp);
        @(negedge i_clk_sys);
        chk(what, {31'h0, v}, {31'h0, exp});
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [31:0] q;
        logic        e;
        rd_chk("preload", `ADDR_PRELOAD, 32'h0000FFFF);
        rd_chk("control", `ADDR_CONTROL, 32'h00000000);
        rd_chk("count", `ADDR_LIVE_COUNT, 32'h0000FFFF);
        rd_chk("service", `ADDR_SERVICE, 32'h00000000);
        rd_chk("irq status", `ADDR_IRQ_STATUS, 32'h00000000);
        bus(1'b0, 24'hF00418, 32'h0, q, e);
        chk("unmapped err", {31'h0, e}, 32'h1);
        wr(`ADDR_LIVE_COUNT, 32'h00001234);
        rd_chk("count ro", `ADDR_LIVE_COUNT, 32'h0000FFFF);
    endtask

    task automatic t_count;
        i_hibernation_active <= 1'b1;
        i_week_timer_active <= 1'b1;
        i_debug_active <= 1'b1;
        wr(`ADDR_PRELOAD, 32'h00000005);
        rd_chk("count load", `ADDR_LIVE_COUNT, 32'h00000005);
        wr(`ADDR_CONTROL, 32'h0000000D);
        repeat (18) @(posedge i_clk_sys);
        rd_chk("count run", `ADDR_LIVE_COUNT, 32'h00000003);
        wr(`ADDR_SERVICE, 32'h000000A5);
        repeat (9) @(posedge i_clk_sys);
        wr(`ADDR_CONTROL, 32'h00000000);
        repeat (18) @(posedge i_clk_sys);
        rd_chk("count kick", `ADDR_LIVE_COUNT, 32'h00000004);
        wr(`ADDR_SERVICE, 32'h000000FF);
        rd_chk("count off", `ADDR_LIVE_COUNT, 32'h00000004);
        wr(`ADDR_CONTROL, 32'h000000E0);
        rd_chk("ctl reserved", `ADDR_CONTROL, 32'h00000000);
        i_debug_active <= 1'b0;
    endtask

    task automatic t_stall;
        wr(`ADDR_PRELOAD, 32'h00000003);
        wr(`ADDR_CONTROL, 32'h00000011);
        repeat (10) @(posedge i_clk_sys);
        i_debug_active <= 1'b1;
        repeat (30) @(posedge i_clk_sys);
        rd_chk("count held", `ADDR_LIVE_COUNT, 32'h00000002);
        i_debug_active <= 1'b0;
        repeat (5) @(posedge i_clk_sys);
        rd_chk("count resumed", `ADDR_LIVE_COUNT, 32'h00000003);
        wr(`ADDR_CONTROL, 32'h00000000);
    endtask

    task automatic t_expiry;
        int n;
        wr(`ADDR_IRQ_MASK, 32'h00000001);
        wr(`ADDR_PRELOAD, 32'h00000002);
        wr(`ADDR_CONTROL, 32'h00000001);
        for (n = 0; n < 100 && o_expiry_pulse !== 1'b1; n++)
            @(posedge i_clk_sys);
        chk("pulse", {31'h0, o_expiry_pulse}, 32'h1);
        wr(`ADDR_CONTROL, 32'h00000000);
        rd_chk("count wrap", `ADDR_LIVE_COUNT, 32'h00000002);
        late_chk("irq", o_irq, 1'b1);
        wr(`ADDR_IRQ_MASK, 32'h00000000);
        late_chk("irq masked", o_irq, 1'b0);
        wr(`ADDR_IRQ_MASK, 32'h00000001);
        wr(`ADDR_IRQ_STATUS, 32'h00000001);
        late_chk("irq cleared", o_irq, 1'b0);
        rd_chk("flag", `ADDR_CONTROL, 32'h00000002);
        @(posedge i_clk_sys);
        i_soft_rst <= 1'b1;
        @(posedge i_clk_sys);
        i_soft_rst <= 1'b0;
        rd_chk("flag kept", `ADDR_CONTROL, 32'h00000002);
        rd_chk("preload reset", `ADDR_PRELOAD, 32'h0000FFFF);
        late_chk("pulse kept", o_expiry_pulse, 1'b1);
        wr(`ADDR_CONTROL, 32'h00000000);
        rd_chk("flag w0", `ADDR_CONTROL, 32'h00000002);
        wr(`ADDR_CONTROL, 32'h00000002);
        rd_chk("flag w1", `ADDR_CONTROL, 32'h00000000);
        for (n = 0; n < 2000 && o_expiry_pulse !== 1'b0; n++)
            @(posedge i_clk_sys);
        late_chk("pulse end", o_expiry_pulse, 1'b0);
    endtask

    initial begin
        error_cnt = 0;
        total_checks = 0;
        i_rst_n = 1'b0;
        i_soft_rst = 1'b0;
        i_debug_active = 1'b0;
        i_hibernation_active = 1'b0;
        i_week_timer_active = 1'b0;
        repeat (3) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        t_reset();
        t_count();
        t_stall();
        t_expiry();
        summarize();
    end
endmodule

bind watchdog_timer_registers watchdog_timer_registers_properties
    watchdog_timer_registers_properties_i (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_soft_rst(i_soft_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata),
    .i_debug_active(i_debug_active), .i_hibernation_active(i_hibernation_active),
    .i_week_timer_active(i_week_timer_active), .o_expiry_pulse(o_expiry_pulse),
    .o_irq(o_irq));

`default_nettype wire

//--- tick_divider.v
`default_nettype none

module tick_divider #(
    parameter [15:0] TICK_CYC = 16'hC4AE
) (
    input  wire i_clk_sys,
    input  wire i_rst_n,
    input  wire i_run,
    input  wire i_restart,
    output wire o_tick
);

    reg  [15:0] cnt_q;
    reg  [15:0] cnt_d;
    wire        last;

    assign last   = (cnt_q == (TICK_CYC - 16'h0001));
    assign o_tick = i_run & ~i_restart & last;

    // holds at zero while stopped so a restart always gives a full period
    always @* begin
        cnt_d = cnt_q;
        if (i_restart || !i_run) begin
            cnt_d = 16'h0000;
        end else if (last) begin
            cnt_d = 16'h0000;
        end else begin
            cnt_d = cnt_q + 16'h0001;
        end
    end

    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule

`default_nettype wire

//--- watchdog_map.vh
`ifndef WATCHDOG_MAP_VH
`define WATCHDOG_MAP_VH

// ------------------------------------------------------------
// register byte addresses (24-bit bus address)
// ------------------------------------------------------------
`define ADDR_PRELOAD       24'hF00400
`define ADDR_CONTROL       24'hF00404
`define ADDR_SERVICE       24'hF00408
`define ADDR_LIVE_COUNT    24'hF0040C
`define ADDR_IRQ_STATUS    24'hF00410
`define ADDR_IRQ_MASK      24'hF00414

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define CTL_COUNTDOWN_EN   0
`define CTL_EXPIRY_FLAG    1
`define CTL_HIBER_HOLD_EN  2
`define CTL_WEEK_HOLD_EN   3
`define CTL_DEBUG_HOLD_EN  4

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_PRELOAD        16'hFFFF
`define RST_LIVE_COUNT     16'hFFFF
`define RST_CONTROL        8'h00
`define RST_IRQ_MASK       1'h0

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS      20
`define TICK_PERIOD_NS     1007000
`define TICK_CYC           16'hC4AE
`define PULSE_NS           30517
`define PULSE_CYC          11'h5F5

`endif

//--- watchdog_timer_registers.v
// Overview of operation
// - preload resets all ones; writing reloads counter
// - debug hold bit lets debug input stall
// - expiry flag set by underflow, survives forced reset
// - write one clears expiry flag
// - countdown enable resets zero; software sets, clears
// - enabled hold inputs start, stop countdown
// - service strobe stores nothing, reads zero
// - service write while enabled reloads, restarts
// - service write ignored while disabled
// - live count read-only, resets all ones
// - decrement once per 1.007 ms tick
// - underflow pulses expiry output, wraps to preload
// - hold stops counter; release reloads preload
// - clearing enable stops counter at once

`include "watchdog_map.vh"
`default_nettype none

module watchdog_timer_registers #(
    parameter [15:0] TICK_CYC = `TICK_CYC
) (
    input  wire        i_clk_sys,
    input  wire        i_rst_n,
    input  wire        i_soft_rst,
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [23:0] i_paddr,
    input  wire [31:0] i_pwdata,
    output wire        o_pready,
    output wire        o_pslverr,
    output reg  [31:0] o_prdata,
    input  wire        i_debug_active,
    input  wire        i_hibernation_active,
    input  wire        i_week_timer_active,
    output reg         o_expiry_pulse,
    output wire        o_irq
);

    // ------------------------------------------------------------
    // register select
    // ------------------------------------------------------------
    localparam [2:0] SEL_PRELOAD = 3'h0;
    localparam [2:0] SEL_CONTROL = 3'h1;
    localparam [2:0] SEL_SERVICE = 3'h2;
    localparam [2:0] SEL_COUNT   = 3'h3;
    localparam [2:0] SEL_ISTAT   = 3'h4;
    localparam [2:0] SEL_IMASK   = 3'h5;
    localparam [2:0] SEL_NONE    = 3'h7;

    localparam [10:0] PULSE_CYC  = `PULSE_CYC;

    function [2:0] reg_select;
        input [23:0] addr;
        begin
            case (addr)
                `ADDR_PRELOAD:    reg_select = SEL_PRELOAD;
                `ADDR_CONTROL:    reg_select = SEL_CONTROL;
                `ADDR_SERVICE:    reg_select = SEL_SERVICE;
                `ADDR_LIVE_COUNT: reg_select = SEL_COUNT;
                `ADDR_IRQ_STATUS: reg_select = SEL_ISTAT;
                `ADDR_IRQ_MASK:   reg_select = SEL_IMASK;
                default:          reg_select = SEL_NONE;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    reg  [15:0] preload_q;
    reg  [15:0] count_q;
    reg  [15:0] count_d;
    reg         enable_q;
    reg         debug_hold_en_q;
    reg         week_hold_en_q;
    reg         hiber_hold_en_q;
    reg         expiry_flag_q;
    reg         irq_status_q;
    reg         irq_mask_q;
    reg         stall_q;
    reg  [10:0] pulse_cnt_q;
    reg  [10:0] pulse_cnt_d;

    wire [2:0]  sel;
    wire        access;
    wire        wr;
    wire        wr_preload;
    wire        wr_control;
    wire        wr_service;
    wire        wr_istat;
    wire        wr_imask;
    wire [2:0]  active_sync;
    wire        stall;
    wire        run;
    wire        activate;
    wire        stall_release;
    wire        kick;
    wire        reload;
    wire        tick;
    wire        underflow;
    wire [7:0]  control_rd;

    // ------------------------------------------------------------
    // apb slave: zero wait states, error on unmapped address
    // ------------------------------------------------------------
    assign sel        = reg_select(i_paddr);
    assign access     = i_psel & i_penable;
    assign o_pready   = 1'b1;
    assign o_pslverr  = access & (sel == SEL_NONE);
    assign wr         = access & i_pwrite;
    assign wr_preload = wr & (sel == SEL_PRELOAD);
    assign wr_control = wr & (sel == SEL_CONTROL);
    assign wr_service = wr & (sel == SEL_SERVICE);
    assign wr_istat   = wr & (sel == SEL_ISTAT);
    assign wr_imask   = wr & (sel == SEL_IMASK);

    assign control_rd = {3'h0,
                         debug_hold_en_q, week_hold_en_q, hiber_hold_en_q,
                         expiry_flag_q, enable_q};

    // read data captured in the setup cycle, stable through access
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h00000000;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            case (sel)
                SEL_PRELOAD: o_prdata <= {16'h0000, preload_q};
                SEL_CONTROL: o_prdata <= {24'h000000, control_rd};
                SEL_SERVICE: o_prdata <= 32'h00000000;
                SEL_COUNT:   o_prdata <= {16'h0000, count_q};
                SEL_ISTAT:   o_prdata <= {31'h00000000, irq_status_q};
                SEL_IMASK:   o_prdata <= {31'h00000000, irq_mask_q};
                default:     o_prdata <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // hold inputs from other blocks
    // ------------------------------------------------------------
    input_sync2 #(
        .W(3)
    ) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_async   ({i_debug_active, i_week_timer_active, i_hibernation_active}),
        .o_sync    (active_sync)
    );

    // bits three and two are expected to stay zero; they still gate their input
    assign stall = enable_q &
                   ((debug_hold_en_q & active_sync[2]) |
                    (week_hold_en_q  & active_sync[1]) |
                    (hiber_hold_en_q & active_sync[0]));

    assign run           = enable_q & ~stall;
    assign activate      = wr_control & i_pwdata[`CTL_COUNTDOWN_EN] & ~enable_q;
    assign stall_release = stall_q & ~stall & enable_q;
    assign kick          = wr_service & enable_q;
    assign reload        = wr_preload | kick | activate | stall_release;

    // ------------------------------------------------------------
    // countdown tick
    // ------------------------------------------------------------
    tick_divider #(
        .TICK_CYC(TICK_CYC)
    ) u_tick (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_run     (run),
        .i_restart (reload),
        .o_tick    (tick)
    );

    // counter passing through one ends the interval
    assign underflow = tick & (count_q <= 16'h0001);

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always @* begin
        count_d = count_q;
        if (wr_preload) begin
            count_d = i_pwdata[15:0];
        end else if (kick || activate || stall_release) begin
            count_d = preload_q;
        end else if (underflow) begin
            count_d = preload_q;
        end else if (tick) begin
            count_d = count_q - 16'h0001;
        end
    end

    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_q   <= `RST_LIVE_COUNT;
            preload_q <= `RST_PRELOAD;
            stall_q   <= 1'b0;
        end else if (i_soft_rst) begin
            count_q   <= `RST_LIVE_COUNT;
            preload_q <= `RST_PRELOAD;
            stall_q   <= 1'b0;
        end else begin
            count_q   <= count_d;
            stall_q   <= stall;
            if (wr_preload) begin
                preload_q <= i_pwdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            enable_q        <= 1'b0;
            debug_hold_en_q <= 1'b0;
            week_hold_en_q  <= 1'b0;
            hiber_hold_en_q <= 1'b0;
        end else if (i_soft_rst) begin
            enable_q        <= 1'b0;
            debug_hold_en_q <= 1'b0;
            week_hold_en_q  <= 1'b0;
            hiber_hold_en_q <= 1'b0;
        end else if (wr_control) begin
            enable_q        <= i_pwdata[`CTL_COUNTDOWN_EN];
            debug_hold_en_q <= i_pwdata[`CTL_DEBUG_HOLD_EN];
            week_hold_en_q  <= i_pwdata[`CTL_WEEK_HOLD_EN];
            hiber_hold_en_q <= i_pwdata[`CTL_HIBER_HOLD_EN];
        end
    end

    // survives the forced reset; only power-on clears it by hardware
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            expiry_flag_q <= 1'b0;
        end else begin
            expiry_flag_q <= underflow |
                             (expiry_flag_q &
                              ~(wr_control & i_pwdata[`CTL_EXPIRY_FLAG]));
        end
    end

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_status_q <= 1'b0;
            irq_mask_q   <= `RST_IRQ_MASK;
        end else if (i_soft_rst) begin
            irq_status_q <= underflow;
            irq_mask_q   <= `RST_IRQ_MASK;
        end else begin
            irq_status_q <= underflow | (irq_status_q & ~(wr_istat & i_pwdata[0]));
            if (wr_imask) begin
                irq_mask_q <= i_pwdata[0];
            end
        end
    end

    assign o_irq = irq_status_q & irq_mask_q;

    // ------------------------------------------------------------
    // expiry pulse stretch to one slow-clock period
    // ------------------------------------------------------------
    always @* begin
        pulse_cnt_d = pulse_cnt_q;
        if (underflow) begin
            pulse_cnt_d = PULSE_CYC;
        end else if (pulse_cnt_q != 11'h000) begin
            pulse_cnt_d = pulse_cnt_q - 11'h001;
        end
    end

    // not cut by the forced reset it triggers
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pulse_cnt_q    <= 11'h000;
            o_expiry_pulse <= 1'b0;
        end else begin
            pulse_cnt_q    <= pulse_cnt_d;
            o_expiry_pulse <= (pulse_cnt_d != 11'h000);
        end
    end

endmodule

`default_nettype wire

//--- watchdog_timer_registers_properties.sv
`include "watchdog_map.vh"
`default_nettype none

module watchdog_timer_registers_properties (
    input wire logic        i_clk_sys,
    input wire logic        i_rst_n,
    input wire logic        i_soft_rst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [23:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic [31:0] o_prdata,
    input wire logic        i_debug_active,
    input wire logic        i_hibernation_active,
    input wire logic        i_week_timer_active,
    input wire logic        o_expiry_pulse,
    input wire logic        o_irq
);
    timeunit 1ns;
    timeprecision 1ps;

    logic        unmapped;
    logic [10:0] pulse_len_q;

    assign unmapped = !(i_paddr inside {`ADDR_PRELOAD, `ADDR_CONTROL, `ADDR_SERVICE,
                                        `ADDR_LIVE_COUNT, `ADDR_IRQ_STATUS, `ADDR_IRQ_MASK});

    // cycles of the current expiry pulse
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n)
            pulse_len_q <= 11'h000;
        else if (o_expiry_pulse)
            pulse_len_q <= pulse_len_q + 11'h001;
        else
            pulse_len_q <= 11'h000;
    end

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_setup_rd(a);
        i_psel && !i_penable && !i_pwrite && (i_paddr == a);
    endsequence

    sequence s_preload_wr;
        i_psel && i_penable && i_pwrite && (i_paddr == `ADDR_PRELOAD);
    endsequence

    a_ready_always: assert property (o_pready)
        else $error("pready low");
    a_err_unmapped: assert property (i_psel && i_penable |-> o_pslverr == unmapped)
        else $error("pslverr wrong");
    a_err_data_zero: assert property (i_psel && !i_penable && !i_pwrite && unmapped
        |=> o_prdata == 32'h00000000) else $error("unmapped read data");
    a_service_reads_zero: assert property (
        s_setup_rd(`ADDR_SERVICE) |=> o_prdata == 32'h00000000) else $error("service read");
    a_ctl_reserved_zero: assert property (
        s_setup_rd(`ADDR_CONTROL) |=> o_prdata[31:5] == 27'h0000000) else $error("ctl high");
    a_count_width_ok: assert property (
        s_setup_rd(`ADDR_LIVE_COUNT) |=> o_prdata[31:16] == 16'h0000) else $error("count high");
    a_preload_reloads_count: assert property (
        s_preload_wr ##2 s_setup_rd(`ADDR_LIVE_COUNT)
        |=> o_prdata[15:0] == $past(i_pwdata[15:0], 3)) else $error("count not reloaded");
    a_prdata_held: assert property (i_psel && i_penable |=> $stable(o_prdata))
        else $error("prdata moved in access");
    a_pulse_length: assert property (
        $fell(o_expiry_pulse) |-> pulse_len_q == `PULSE_CYC) else $error("pulse length");
endmodule

`default_nettype wire
